// file: ppi_params.svh
// How it works
// R1 - Capture index, overlay select, sync and blank together on each clock edge.
// R2 - Captured blank low forces blanking level and ignores index and overlay.
// R3 - Captured 8-bit index, bit 0 least, picks one of 256 palette entries.
// R4 - Nonzero overlay select picks an overlay colour register; index is ignored.
// R5 - Captured sync low removes sync current; sync overrides nothing else.
// R6 - Controller drives sync low only while blank is also low.
// R7 - Pedestal select pin: low gives 0 IRE, high gives 7.5 IRE.
// R8 - In extended mode the command pedestal bit ANDed with mode pin governs pedestal.
// R9 - Command bits enable sync current on blue, green and red separately.
// R10 - Controls and colour stay aligned through a fixed pipeline latency.
`ifndef PPI_PARAMS_SVH
`define PPI_PARAMS_SVH
// ==========================================
// Register map
`define PPI_ADDR_CMD 12'h000
`define PPI_ADDR_STATUS 12'h004
`define PPI_ADDR_PAL 12'h400
`define PPI_ADDR_OVL 12'h800
`define PPI_CMD_RESET 8'h40
`define PPI_CMD_PED_BIT 5
`define PPI_CMD_BSYNC_BIT 4
`define PPI_CMD_GSYNC_BIT 3
`define PPI_CMD_RSYNC_BIT 2
`define PPI_PIPE_DEPTH 2
`endif

// file: ppi_pkg.sv
package ppi_pkg;
    typedef struct packed {
        logic [7:0] pixelIndex;
        logic [3:0] overlaySelect;
        logic syncN;
        logic blankN;
    } ppi_pixel_s;
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic blankLevel;
        logic pedestal;
        logic syncRed;
        logic syncGreen;
        logic syncBlue;
    } ppi_out_s;
endpackage : ppi_pkg

// file: ppi_palette_mem.sv
`timescale 1ns/1ns
`default_nettype none
module ppi_palette_mem #(
    parameter int DEPTH = 256,
    parameter int AW = 8,
    parameter int DW = 24
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddrA,
    output logic [DW-1:0] rdataA,
    input wire logic [AW-1:0] raddrB,
    output logic [DW-1:0] rdataB
);
    logic [DW-1:0] mem [DEPTH];
    // Two registered read ports: pixel path and software readback
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdataA <= mem[raddrA];
        rdataB <= mem[raddrB];
    end
endmodule : ppi_palette_mem
`default_nettype wire

// file: ppi_pixel_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "ppi_params.svh"
module ppi_pixel_port (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] pixelIndex,
    input wire logic [3:0] overlaySelect,
    input wire logic syncN,
    input wire logic blankN,
    input wire logic pedestalSelect,
    input wire logic extendedMode,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output ppi_pkg::ppi_out_s colourCurrentOutputs
);
    // ==========================================
    // State
    typedef struct packed {
        ppi_pkg::ppi_pixel_s cap;
        ppi_pkg::ppi_pixel_s stage;
        logic [23:0] ovlColour;
        logic [7:0] cmd;
        logic [31:0] rdata;
        logic err;
        logic rdPend;
        ppi_pkg::ppi_out_s out;
    } ppi_state_s;
    ppi_state_s st, next_st;
    logic [23:0] ovlReg [1:15];
    logic [23:0] palPix, palBus;
    logic access, palWe, pedestalEff;
    assign access = psel && penable;
    // Palette reads take one extra cycle through the memory register
    assign pready = !(access && !pwrite && paddr[11:10] == 2'b01 && !st.rdPend);
    assign pslverr = st.err;
    assign prdata = st.rdata;
    assign colourCurrentOutputs = st.out;
    assign palWe = access && pwrite && paddr[11:10] == 2'b01;
    assign pedestalEff = extendedMode ? st.cmd[`PPI_CMD_PED_BIT] && extendedMode
                                      : pedestalSelect; // R7 R8
    ppi_palette_mem #(.DEPTH(256), .AW(8), .DW(24)) uMem (
        .clk(clk),
        .we(palWe),
        .waddr(paddr[9:2]),
        .wdata(pwdata[23:0]),
        .raddrA(st.cap.pixelIndex), // R3
        .rdataA(palPix),
        .raddrB(paddr[9:2]),
        .rdataB(palBus)
    );
    // ==========================================
    // Overlay registers, writes only from APB
    always_ff @(posedge clk) begin
        if (access && pwrite && paddr[11:10] == 2'b10 && paddr[5:2] != 4'h0) begin
            ovlReg[paddr[5:2]] <= pwdata[23:0];
        end
    end
    // ==========================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.cap = '{pixelIndex, overlaySelect, syncN, blankN}; // R1
        next_st.stage = st.cap; // R10
        next_st.ovlColour = (st.cap.overlaySelect == 4'h0) ? 24'h000000
                                                        : ovlReg[st.cap.overlaySelect];
        next_st.err = 1'b0;
        next_st.rdPend = access && !pwrite && !st.rdPend && paddr[11:10] == 2'b01;
        if (!st.stage.blankN) begin
            next_st.out.red = 8'h00; // R2
            next_st.out.green = 8'h00;
            next_st.out.blue = 8'h00;
            next_st.out.blankLevel = 1'b1;
        end else if (st.stage.overlaySelect != 4'h0) begin
            {next_st.out.red, next_st.out.green, next_st.out.blue} = st.ovlColour; // R4
            next_st.out.blankLevel = 1'b0;
        end else begin
            {next_st.out.red, next_st.out.green, next_st.out.blue} = palPix; // R3
            next_st.out.blankLevel = 1'b0;
        end
        next_st.out.pedestal = pedestalEff; // R7
        // Sync gates only the sync current, never the colour or blank level
        next_st.out.syncRed = st.stage.syncN && st.cmd[`PPI_CMD_RSYNC_BIT]; // R5 R9
        next_st.out.syncGreen = st.stage.syncN && st.cmd[`PPI_CMD_GSYNC_BIT]; // R5 R9
        next_st.out.syncBlue = st.stage.syncN && st.cmd[`PPI_CMD_BSYNC_BIT]; // R5 R9
        // Read data and error are registered from the decode while psel stands,
        // so both are already valid in the cycle in which pready is high
        next_st.rdata = 32'h00000000;
        if (access && pready && pwrite && paddr == `PPI_ADDR_CMD) begin
            next_st.cmd = pwdata[7:0];
        end
        if (psel) begin
            if (paddr == `PPI_ADDR_CMD) begin
                next_st.rdata = {24'h000000, st.cmd};
            end else if (paddr == `PPI_ADDR_STATUS) begin
                next_st.rdata = {18'h00000, st.cap.syncN, st.cap.blankN,
                                 st.cap.overlaySelect, st.cap.pixelIndex};
                next_st.err = pwrite;
            end else if (paddr[11:10] == 2'b01) begin
                next_st.rdata = {8'h00, palBus};
            end else if (paddr[11:10] == 2'b10) begin
                next_st.rdata = (paddr[5:2] == 4'h0) ? 32'h00000000
                                                     : {8'h00, ovlReg[paddr[5:2]]};
            end else begin
                next_st.rdata = 32'h00000000;
                next_st.err = 1'b1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
            st.cap.syncN <= 1'b1;
            st.stage.syncN <= 1'b1;
            st.out.blankLevel <= 1'b1;
            st.cmd <= `PPI_CMD_RESET;
        end else begin
            st <= next_st;
        end
    end
    // ==========================================
    // Checks
    sequence s_blank_in;
        !blankN ##`PPI_PIPE_DEPTH 1'b1;
    endsequence
    AST_BLANK: assert property (@(posedge clk) disable iff (sys_rst)
        s_blank_in |=> colourCurrentOutputs.blankLevel) // R2
        else $error("blank not applied");
    AST_BLANK_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
        !blankN ##3 1'b1 |-> colourCurrentOutputs.red == 8'h00) // R2
        else $error("blank colour not zero");
    AST_CAPTURE: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> st.cap.pixelIndex == $past(pixelIndex)) // R1
        else $error("index not captured");
    // The stage register holds a reset value for one edge after release
    AST_ALIGN: assert property (@(posedge clk) disable iff (sys_rst)
        !$past(sys_rst) |=> st.stage.overlaySelect == $past(overlaySelect, 2)) // R10
        else $error("pipeline misaligned");
    AST_SYNC_OFF: assert property (@(posedge clk) disable iff (sys_rst)
        !syncN ##3 1'b1 |-> !colourCurrentOutputs.syncGreen) // R5
        else $error("sync current not removed");
    AST_SYNC_NO_OVERRIDE: assert property (@(posedge clk) disable iff (sys_rst)
        blankN && !syncN ##3 1'b1 |-> !colourCurrentOutputs.blankLevel) // R5
        else $error("sync overrode data");
    AST_OVERLAY: assert property (@(posedge clk) disable iff (sys_rst)
        blankN && overlaySelect != 4'h0 ##3 1'b1
        |-> colourCurrentOutputs.blue == $past(st.ovlColour[7:0])) // R4
        else $error("overlay not chosen");
    AST_PEDESTAL: assert property (@(posedge clk) disable iff (sys_rst)
        !extendedMode |=> colourCurrentOutputs.pedestal == $past(pedestalSelect)) // R7
        else $error("pedestal pin ignored");
    AST_PED_EXT: assert property (@(posedge clk) disable iff (sys_rst)
        extendedMode |=> colourCurrentOutputs.pedestal
                         == $past(st.cmd[`PPI_CMD_PED_BIT])) // R8
        else $error("command pedestal ignored");
    AST_SYNC_EN: assert property (@(posedge clk) disable iff (sys_rst)
        !st.cmd[`PPI_CMD_RSYNC_BIT] && $stable(st.cmd) |=> !colourCurrentOutputs.syncRed) // R9
        else $error("red sync not disabled");
endmodule : ppi_pixel_port
`default_nettype wire

// file: ppi_gfx_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Graphics controller model
module ppi_gfx_ctrl (
    input wire logic clk,
    input wire logic run,
    output ppi_pkg::ppi_pixel_s pix
);
    int seed = 46;
    logic [3:0] r;
    initial pix = '{8'h00, 4'h0, 1'b1, 1'b0};
    always @(posedge clk) begin
        r = 4'($random(seed));
        pix.pixelIndex <= 8'($random(seed));
        pix.overlaySelect <= r[3] ? 4'($random(seed)) : 4'h0;
        // Idle time is blanked so the port never sees stale colour
        pix.blankN <= run && r[1:0] != 2'h0;
        pix.syncN <= !(run && r[1:0] == 2'h0 && r[2]);
    end
endmodule : ppi_gfx_ctrl
`default_nettype wire

// file: ppi_testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 0, sysRst = 1, ped = 0, ext = 1, run = 0, mon = 0, err;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [23:0] pal [256];
    logic [23:0] ovl [16];
    logic [7:0] cmd = 8'h40;
    logic [7:0] cmdTab [4] = '{8'h64, 8'h48, 8'h70, 8'h5C};
    logic [2:0] vld = '0;
    int errorCnt = 0, comparisons = 0, cyc = 0, seed = 46;
    ppi_pkg::ppi_pixel_s pix;
    ppi_pkg::ppi_out_s co, e, m;
    ppi_pkg::ppi_out_s expQ[$], mskQ[$];
    always #4 clk = ~clk;
    ppi_gfx_ctrl gfx_u (.clk(clk), .run(run), .pix(pix));
    ppi_pixel_port dut_u (.clk(clk), .sys_rst(sysRst), .pixelIndex(pix.pixelIndex),
        .overlaySelect(pix.overlaySelect), .syncN(pix.syncN), .blankN(pix.blankN),
        .pedestalSelect(ped), .extendedMode(ext), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .colourCurrentOutputs(co));
    // ==========
    // Checks and bus
    task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask : chkReg
    task automatic chkPix(input ppi_pkg::ppi_out_s got, exp, msk);
        comparisons++;
        if ((got & msk) !== (exp & msk)) begin
            errorCnt++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask : chkPix
    // Read data and error are taken at the completing edge; one idle edge follows
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask : apb
    task automatic finalReport();
        $display("errors %0d comparisons %0d", errorCnt, comparisons);
        if (errorCnt == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finalReport
    // ==========
    // Scoreboard: note at capture, compare three edges later
    always @(posedge clk) begin
        if (vld[2]) chkPix(co, expQ.pop_front(), mskQ.pop_front());
        vld <= {vld[1:0], mon};
        if (mon) begin
            e = '0;
            m = '1;
            {e.red, e.green, e.blue} = pix.overlaySelect != 4'h0 ? ovl[pix.overlaySelect]
                : pal[pix.pixelIndex];
            e.blankLevel = !pix.blankN;
            e.pedestal = ext ? cmd[5] : ped;
            {e.syncBlue, e.syncGreen, e.syncRed} = {3{pix.syncN}} & cmd[4:2];
            if (!pix.blankN) {m.red, m.green, m.blue} = '0;
            if (!ext) {m.syncRed, m.syncGreen, m.syncBlue} = '0;
            expQ.push_back(e);
            mskQ.push_back(m);
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errorCnt++;
            finalReport();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        sysRst <= 0;
        @(posedge clk);
        apb(0, 12'h000, 0);
        chkReg(rd, 32'h40);
        for (int i = 0; i < 256; i++) begin
            pal[i] = 24'($random(seed));
            apb(1, 12'h400 + 12'(4 * i), {8'h00, pal[i]});
        end
        for (int i = 1; i < 16; i++) begin
            ovl[i] = 24'($random(seed));
            apb(1, 12'h800 + 12'(4 * i), {8'h00, ovl[i]});
        end
        apb(0, 12'h7FC, 0);
        chkReg(rd, {8'h00, pal[255]});
        apb(0, 12'hC00, 0);
        chkReg({rd[30:0], err}, 32'h1);
        apb(1, 12'h004, 32'h5A);
        chkReg({31'h0, err}, 32'h1);
        // Modes change only while the pipeline is empty
        for (int p = 0; p < 6; p++) begin
            repeat (6) @(posedge clk);
            ext <= p < 4;
            ped <= p[0];
            cmd = cmdTab[p % 4];
            apb(1, 12'h000, {24'h0, cmd});
            run <= 1;
            mon <= 1;
            repeat (300) @(posedge clk);
            run <= 0;
            mon <= 0;
        end
        repeat (6) @(posedge clk);
        finalReport();
    end
endmodule : testbench
`default_nettype wire
